// ### blc_defs.vh
`ifndef BLC_DEFS_VH
`define BLC_DEFS_VH

// ----------------------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------------------
`define BLC_WORD_BITS 16
`define BLC_ADDR_MSB 13
`define BLC_ADDR_LSB 10
`define BLC_DATA_MSB 9
`define BLC_DATA_LSB 0

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define BLC_ADDR_CTRL1 4'h0
`define BLC_ADDR_COARSE 4'h4
`define BLC_ADDR_FINE 4'h5
`define BLC_ADDR_BLACK_REF 4'h6
`define BLC_ADDR_SETUP 4'h7
`define BLC_ADDR_LIMIT 4'h8
`define BLC_ADDR_FILTER 4'ha

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BLC_CTRL1_COARSE_MAN 6
`define BLC_CTRL1_FINE_MAN 5
`define BLC_DAC_SIGN 8
`define BLC_SETUP_OUT_SEL_HI 9
`define BLC_SETUP_OUT_SEL_LO 8
`define BLC_SETUP_HYS_OFF 7
`define BLC_SETUP_SOFW_HI 5
`define BLC_SETUP_SOFW_LO 4
`define BLC_SETUP_TRIPLE 3
`define BLC_SETUP_EXP_HI 2
`define BLC_SETUP_EXP_LO 0
`define BLC_LIMIT_FILTER_OFF 0
`define BLC_FLT_FRAME_START 9
`define BLC_FLT_OFFSET_TEST 8
`define BLC_FLT_AUTO_SOF 7
`define BLC_FLT_VIDEO_GND 6
`define BLC_FLT_INPUT_MODE 5
`define BLC_FLT_CLAMP_SEL 4
`define BLC_FLT_WEIGHT_HI 3
`define BLC_FLT_WEIGHT_LO 0

// ----------------------------------------------------------------------------
// writable-bit masks and reset values
// ----------------------------------------------------------------------------
`define BLC_CTRL1_MASK 10'h060
`define BLC_DAC_MASK 10'h1ff
`define BLC_SETUP_MASK 10'h3bf
`define BLC_LIMIT_MASK 10'h001
`define BLC_FLT_MASK 10'h3ff
`define BLC_CTRL1_RESET 10'h000
`define BLC_DAC_RESET 10'h000
`define BLC_BLACK_REF_RESET 10'h040
`define BLC_SETUP_RESET 10'h003
`define BLC_LIMIT_RESET 10'h001
`define BLC_FLT_RESET 10'h007

// ----------------------------------------------------------------------------
// numeric limits
// ----------------------------------------------------------------------------
`define BLC_EXP_MAX 3'h6
`define BLC_WEIGHT_MAX 4'h8
`define BLC_OFFSET_TEST_VALUE 8'hff

`endif

// ### blc_serial_rx.v
`timescale 1ns/1ns
`default_nettype none
`include "blc_defs.vh"

// ----------------------------------------------------------------------------
// serial configuration receiver
// ----------------------------------------------------------------------------
// all pins pass two flops first; the serial clock must stay well below clk_i/4
module blc_serial_rx (
  input wire clk_i,
  input wire nrst_i,
  input wire ser_clk_i,
  input wire ser_data_i,
  input wire ser_frame_n_i,
  output reg [`BLC_WORD_BITS-1:0] word_o,
  output reg word_valid_o
);

  reg [2:0] clk_sync_q;
  reg [1:0] data_sync_q;
  reg [2:0] frame_sync_q;
  reg [`BLC_WORD_BITS-1:0] shift_q;
  reg [4:0] count_q;
  wire sclk_rise;
  wire frame_end;
  wire in_frame;

  // bit 2 of the clock and frame chains is an edge history flop, read after the two-stage sync
  assign sclk_rise = clk_sync_q[1] & ~clk_sync_q[2];
  assign frame_end = frame_sync_q[1] & ~frame_sync_q[2];
  assign in_frame = ~frame_sync_q[1];

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      clk_sync_q <= 3'h0;
      data_sync_q <= 2'h0;
      frame_sync_q <= 3'h7;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], ser_clk_i};
      data_sync_q <= {data_sync_q[0], ser_data_i};
      frame_sync_q <= {frame_sync_q[1:0], ser_frame_n_i};
    end
  end

  // a frame with fewer than 16 bits is dropped, longer keeps the last 16
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      word_o <= 16'h0000;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      if (!in_frame) begin
        count_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[`BLC_WORD_BITS-2:0], data_sync_q[1]};
        if (count_q != 5'h10) begin
          count_q <= count_q + 5'h01;
        end
      end
      if (frame_end && count_q == 5'h10) begin
        word_o <= shift_q;
        word_valid_o <= 1'b1;
      end
    end
  end

endmodule // blc_serial_rx

`default_nettype wire

// ### blc_config.v
`timescale 1ns/1ns
`default_nettype none
`include "blc_defs.vh"

// Behaviour
// R1 - offset DAC bit 8 picks sign, 0 positive
// R2 - coarse DAC uses register only in manual mode
// R3 - fine DAC uses register only in manual mode
// R4 - ten-bit black reference, resets to 40 hex
// R5 - setup bits 9:8 select output data source
// R6 - setup bit 7 removes fine DAC hysteresis
// R7 - frame-start mode weight taken from setup bits 5:4
// R8 - average 2^N black pixels, saturate at 64
// R9 - triple bit multiplies pixel count by three
// R10 - limit bit 0 clear enables outlier rejection
// R11 - frame-start bit marks new frame, one-line weight
// R12 - test bit adds 255 to black pixels
// R13 - auto frame start on major gain change
// R14 - ground bit shorts video input to ground
// R15 - input mode: 0 sensor, 1 video
// R16 - weight code gives power-of-two fraction, reset 1/128
// R17 - mode bit 0 automatic, 1 programmed value
// R18 - host writes 16-bit words: address plus data
// R19 - reserved bits ignored on write

module blc_config (
  input wire clk_i,
  input wire nrst_i,
  input wire ser_clk_i,
  input wire ser_data_i,
  input wire ser_frame_n_i,
  input wire [8:0] coarse_auto_i,
  input wire [8:0] fine_auto_i,
  input wire gain_major_change_i,
  input wire line_end_i,
  output reg [7:0] coarse_dac_code_o,
  output reg coarse_dac_neg_o,
  output reg [7:0] fine_dac_code_o,
  output reg fine_dac_neg_o,
  output reg coarse_manual_mode_o,
  output reg fine_manual_mode_o,
  output reg fine_dac_hysteresis_off_o,
  output reg [9:0] black_reference_o,
  output reg [1:0] out_select_o,
  output reg [7:0] black_pixel_count_o,
  output reg outlier_filter_en_o,
  output reg [7:0] black_offset_add_o,
  output reg frame_start_o,
  output reg frame_start_mode_o,
  output reg filter_skip_o,
  output reg [1:0] frame_start_weight_o,
  output reg [3:0] filter_weight_shift_o,
  output reg video_input_ground_o,
  output reg input_mode_select_o,
  output reg video_clamp_select_o
);

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  function [7:0] pixel_count;
    input [2:0] exponent;
    input triple;
    reg [2:0] n;
    reg [7:0] base;
    begin
      n = (exponent > `BLC_EXP_MAX) ? `BLC_EXP_MAX : exponent; // R8
      base = 8'h01 << n; // R8
      pixel_count = triple ? (base + (base << 1)) : base; // R9
    end
  endfunction

  function [7:0] dac_select;
    input manual;
    input [7:0] programmed;
    input [7:0] auto_value;
    begin
      dac_select = manual ? programmed : auto_value;
    end
  endfunction

  // --------------------------------------------------------------------------
  // serial port
  // --------------------------------------------------------------------------
  wire [15:0] rx_word;
  wire rx_valid;

  blc_serial_rx u_rx (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i),
    .ser_frame_n_i(ser_frame_n_i),
    .word_o(rx_word),
    .word_valid_o(rx_valid)
  );

  wire [3:0] wr_addr;
  wire [9:0] wr_data;
  assign wr_addr = rx_word[`BLC_ADDR_MSB:`BLC_ADDR_LSB]; // R18
  assign wr_data = rx_word[`BLC_DATA_MSB:`BLC_DATA_LSB]; // R18

  // --------------------------------------------------------------------------
  // register bank
  // --------------------------------------------------------------------------
  reg [9:0] ctrl1_q;
  reg [9:0] coarse_q;
  reg [9:0] fine_q;
  reg [9:0] black_ref_q;
  reg [9:0] setup_q;
  reg [9:0] limit_q;
  reg [9:0] filter_q;

  // unmapped and out-of-scope addresses are ignored here
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl1_q <= `BLC_CTRL1_RESET; // R17
      coarse_q <= `BLC_DAC_RESET; // R1
      fine_q <= `BLC_DAC_RESET;
      black_ref_q <= `BLC_BLACK_REF_RESET; // R4
      setup_q <= `BLC_SETUP_RESET;
      limit_q <= `BLC_LIMIT_RESET; // R10
      filter_q <= `BLC_FLT_RESET; // R16
    end else if (rx_valid) begin
      case (wr_addr)
        `BLC_ADDR_CTRL1: begin
          ctrl1_q <= wr_data & `BLC_CTRL1_MASK; // R19
        end
        `BLC_ADDR_COARSE: begin
          coarse_q <= wr_data & `BLC_DAC_MASK; // R19
        end
        `BLC_ADDR_FINE: begin
          fine_q <= wr_data & `BLC_DAC_MASK; // R19
        end
        `BLC_ADDR_BLACK_REF: begin
          black_ref_q <= wr_data; // R4
        end
        `BLC_ADDR_SETUP: begin
          setup_q <= wr_data & `BLC_SETUP_MASK; // R19
        end
        `BLC_ADDR_LIMIT: begin
          limit_q <= wr_data & `BLC_LIMIT_MASK; // R19
        end
        `BLC_ADDR_FILTER: begin
          filter_q <= wr_data & `BLC_FLT_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------------
  wire coarse_manual;
  wire fine_manual;
  wire sof_bit;
  wire auto_sof;
  wire [3:0] weight_code;
  wire sof_write;
  wire coarse_sign;
  wire fine_sign;
  wire [7:0] coarse_magnitude;
  wire [7:0] fine_magnitude;
  wire [1:0] out_select;
  wire hysteresis_off;
  wire [1:0] sof_weight;
  wire count_triple;
  wire [2:0] count_exponent;
  wire filter_off;
  wire offset_test;
  wire video_ground;
  wire input_mode;
  wire clamp_select;

  assign coarse_manual = ctrl1_q[`BLC_CTRL1_COARSE_MAN]; // R17
  assign fine_manual = ctrl1_q[`BLC_CTRL1_FINE_MAN]; // R17
  assign sof_bit = filter_q[`BLC_FLT_FRAME_START];
  assign auto_sof = filter_q[`BLC_FLT_AUTO_SOF];
  assign weight_code = filter_q[`BLC_FLT_WEIGHT_HI:`BLC_FLT_WEIGHT_LO];
  assign sof_write = rx_valid && (wr_addr == `BLC_ADDR_FILTER) &&
                     wr_data[`BLC_FLT_FRAME_START];
  assign coarse_sign = coarse_q[`BLC_DAC_SIGN]; // R1
  assign fine_sign = fine_q[`BLC_DAC_SIGN]; // R1
  assign coarse_magnitude = coarse_q[7:0]; // R2
  assign fine_magnitude = fine_q[7:0]; // R3
  assign out_select = {setup_q[`BLC_SETUP_OUT_SEL_HI], setup_q[`BLC_SETUP_OUT_SEL_LO]}; // R5
  assign hysteresis_off = setup_q[`BLC_SETUP_HYS_OFF]; // R6
  assign sof_weight = {setup_q[`BLC_SETUP_SOFW_HI], setup_q[`BLC_SETUP_SOFW_LO]}; // R7
  assign count_triple = setup_q[`BLC_SETUP_TRIPLE]; // R9
  assign count_exponent = setup_q[`BLC_SETUP_EXP_HI:`BLC_SETUP_EXP_LO]; // R8
  assign filter_off = limit_q[`BLC_LIMIT_FILTER_OFF]; // R10
  assign offset_test = filter_q[`BLC_FLT_OFFSET_TEST]; // R12
  assign video_ground = filter_q[`BLC_FLT_VIDEO_GND]; // R14
  assign input_mode = filter_q[`BLC_FLT_INPUT_MODE]; // R15
  assign clamp_select = filter_q[`BLC_FLT_CLAMP_SEL];

  // --------------------------------------------------------------------------
  // frame-start tracking
  // --------------------------------------------------------------------------
  // first_line_q: the line right after a frame start averages one line only;
  // auto_line_q: the line after a major gain change skips filtering
  reg first_line_q;
  reg auto_line_q;
  wire auto_trigger;

  assign auto_trigger = auto_sof & gain_major_change_i; // R13

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      first_line_q <= 1'b0;
      auto_line_q <= 1'b0;
    end else begin
      // a new trigger in the line-end cycle wins over the clear
      if (sof_write || auto_trigger) begin
        first_line_q <= 1'b1; // R11
      end else if (line_end_i) begin
        first_line_q <= 1'b0;
      end
      if (auto_trigger) begin
        auto_line_q <= 1'b1; // R13
      end else if (line_end_i) begin
        auto_line_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      coarse_dac_code_o <= 8'h00;
      coarse_dac_neg_o <= 1'b0;
      fine_dac_code_o <= 8'h00;
      fine_dac_neg_o <= 1'b0;
      coarse_manual_mode_o <= 1'b0;
      fine_manual_mode_o <= 1'b0;
    end else begin
      coarse_manual_mode_o <= coarse_manual; // R17
      fine_manual_mode_o <= fine_manual; // R17
      coarse_dac_code_o <= dac_select(coarse_manual, coarse_magnitude,
                                      coarse_auto_i[7:0]); // R2
      fine_dac_code_o <= dac_select(fine_manual, fine_magnitude, fine_auto_i[7:0]); // R3
      // in automatic mode the calibration loop supplies the sign as well
      coarse_dac_neg_o <= coarse_manual ? coarse_sign : coarse_auto_i[8]; // R1
      fine_dac_neg_o <= fine_manual ? fine_sign : fine_auto_i[8]; // R1
    end
  end

  // --------------------------------------------------------------------------
  // black reference, setup, limit and filter outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      fine_dac_hysteresis_off_o <= 1'b0;
      black_reference_o <= `BLC_BLACK_REF_RESET;
      out_select_o <= 2'h0;
      black_pixel_count_o <= 8'h08;
      outlier_filter_en_o <= 1'b0;
      black_offset_add_o <= 8'h00;
      filter_weight_shift_o <= 4'h7;
      video_input_ground_o <= 1'b0;
      input_mode_select_o <= 1'b0;
      video_clamp_select_o <= 1'b0;
    end else begin
      fine_dac_hysteresis_off_o <= hysteresis_off; // R6
      black_reference_o <= black_ref_q; // R4
      out_select_o <= out_select; // R5
      black_pixel_count_o <= pixel_count(count_exponent, count_triple); // R8
      outlier_filter_en_o <= ~filter_off; // R10
      black_offset_add_o <= offset_test ? `BLC_OFFSET_TEST_VALUE : 8'h00; // R12
      // codes beyond 1/256 have no finer step, so they saturate there
      filter_weight_shift_o <= (weight_code > `BLC_WEIGHT_MAX) ?
                               `BLC_WEIGHT_MAX : weight_code; // R16
      video_input_ground_o <= video_ground; // R14
      input_mode_select_o <= input_mode; // R15
      video_clamp_select_o <= clamp_select;
    end
  end

  // --------------------------------------------------------------------------
  // frame-start outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      frame_start_o <= 1'b0;
      frame_start_mode_o <= 1'b0;
      filter_skip_o <= 1'b0;
      frame_start_weight_o <= 2'h0;
    end else begin
      // pulse at the edge that takes the word, or on a gain-change trigger
      frame_start_o <= sof_write | auto_trigger; // R11
      frame_start_mode_o <= sof_bit | first_line_q | auto_line_q; // R13
      filter_skip_o <= auto_line_q; // R13
      if (first_line_q) begin
        frame_start_weight_o <= 2'h1; // R11
      end else begin
        frame_start_weight_o <= sof_weight; // R7
      end
    end
  end

endmodule // blc_config

`default_nettype wire

// ### blc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// host side of the serial configuration port
// ----------------------------------------------------------------------------
// clock rests low and frame high between words; data flips once released
module blc_host_model (
  input wire logic clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_frame_n_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_frame_n_o = 1'b1;
  end

  // n bits from the top of w, each phase ph clocks long
  task automatic send(input logic [15:0] w, input int n, input int ph);
    int i;
    @(posedge clk_i);
    #2 ser_frame_n_o = 1'b0;
    for (i = 15; i > 15 - n; i--) begin
      ser_data_o = w[i];
      repeat (ph) @(posedge clk_i);
      #2 ser_clk_o = 1'b1;
      repeat (ph) @(posedge clk_i);
      #2 ser_clk_o = 1'b0;
    end
    repeat (ph) @(posedge clk_i);
    #2 ser_frame_n_o = 1'b1;
    ser_data_o = ~ser_data_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // blc_host_model
`default_nettype wire

// ### blc_config_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module blc_config_asserts (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ser_frame_n_i,
  input wire logic [8:0] coarse_auto_i,
  input wire logic [8:0] fine_auto_i,
  input wire logic gain_major_change_i,
  input wire logic line_end_i,
  input wire logic [7:0] coarse_dac_code_o,
  input wire logic coarse_dac_neg_o,
  input wire logic [7:0] fine_dac_code_o,
  input wire logic fine_dac_neg_o,
  input wire logic coarse_manual_mode_o,
  input wire logic fine_manual_mode_o,
  input wire logic [9:0] black_reference_o,
  input wire logic [7:0] black_pixel_count_o,
  input wire logic [7:0] black_offset_add_o,
  input wire logic frame_start_o,
  input wire logic frame_start_mode_o,
  input wire logic filter_skip_o,
  input wire logic [1:0] frame_start_weight_o,
  input wire logic [3:0] filter_weight_shift_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------------------------------------------
  // clocks since the frame pin last rose
  // ----------------------------------------------------------------------------
  logic frame_q;
  logic [3:0] since_q;
  always @(posedge clk_i) begin
    frame_q <= ser_frame_n_i;
    if (!nrst_i) since_q <= 4'hf;
    else if (ser_frame_n_i && !frame_q) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end

  sequence s_line_close;
    line_end_i && !gain_major_change_i && !frame_start_o;
  endsequence
  sequence s_start_quiet;
    frame_start_o ##1 !line_end_i;
  endsequence

  AST_COARSE_AUTO: assert property (!coarse_manual_mode_o && !fine_manual_mode_o
    && $past(!coarse_manual_mode_o && nrst_i) |-> coarse_dac_code_o == $past(coarse_auto_i[7:0])
    && coarse_dac_neg_o == $past(coarse_auto_i[8])) else $error("coarse auto value wrong");
  AST_FINE_AUTO: assert property (!fine_manual_mode_o && $past(!fine_manual_mode_o && nrst_i)
    |-> fine_dac_code_o == $past(fine_auto_i[7:0]) && fine_dac_neg_o == $past(fine_auto_i[8]))
    else $error("fine auto value wrong");
  AST_REF_WRITE: assert property ($changed(black_reference_o) && $past(nrst_i)
    |-> since_q inside {[2:7]}) else $error("reference changed without a write");
  AST_PIX_COUNT: assert property (black_pixel_count_o inside {1, 2, 3, 4, 6, 8, 12, 16,
    24, 32, 48, 64, 96, 192}) else $error("pixel count illegal");
  AST_WEIGHT_SAT: assert property (filter_weight_shift_o <= 4'h8)
    else $error("weight beyond 1/256");
  AST_OFFSET_TEST: assert property (black_offset_add_o inside {8'h00, 8'hff})
    else $error("test offset illegal");
  AST_SKIP_ENTRY: assert property ($rose(filter_skip_o) |-> $past(frame_start_o))
    else $error("skip without frame start");
  AST_SKIP_MODE: assert property (filter_skip_o |-> frame_start_mode_o)
    else $error("skip outside frame start mode");
  AST_SKIP_CLEAR: assert property (s_line_close |-> ##[1:2] !filter_skip_o)
    else $error("skip held past line end");
  AST_SOF_WEIGHT: assert property (s_start_quiet |-> ##[0:1] frame_start_weight_o == 2'h1)
    else $error("first line weight not one");
endmodule // blc_config_asserts

bind blc_config blc_config_asserts chk_u (.*);
`default_nettype wire

// ### tb_black_level_calibration_config.sv
`timescale 1ns/1ns
`default_nettype none
module tb_black_level_calibration_config;
  logic clk_i, nrst_i, gain_major_change_i, line_end_i;
  logic [8:0] coarse_auto_i, fine_auto_i;
  wire ser_clk_i, ser_data_i, ser_frame_n_i;
  wire [7:0] coarse_dac_code_o, fine_dac_code_o, black_pixel_count_o, black_offset_add_o;
  wire coarse_dac_neg_o, fine_dac_neg_o, coarse_manual_mode_o, fine_manual_mode_o;
  wire fine_dac_hysteresis_off_o, outlier_filter_en_o, frame_start_o, frame_start_mode_o;
  wire filter_skip_o, video_input_ground_o, input_mode_select_o, video_clamp_select_o;
  wire [9:0] black_reference_o;
  wire [1:0] out_select_o, frame_start_weight_o;
  wire [3:0] filter_weight_shift_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int i;
  logic [9:0] d;
  logic [9:0] sv [7] = '{10'h000, 10'h007, 10'h00e, 10'h0cb, 10'h335, 10'h2f4, 10'h01a};
  logic [9:0] cnt [7] = '{10'h001, 10'h040, 10'h0c0, 10'h018, 10'h020, 10'h010, 10'h00c};

  blc_config dut_u (.*);
  blc_host_model host_u (.clk_i(clk_i), .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .ser_frame_n_o(ser_frame_n_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [9:0] v);
    host_u.send({2'h0, a, v}, 16, 3);
    repeat (8) @(posedge clk_i);
    #2;
  endtask

  // the pulse lasts one clock, so it is sampled just after each edge
  task automatic wait_sof;
    int k;
    for (k = 0; k < 30; k++) begin
      #1;
      if (frame_start_o === 1'b1) break;
      @(posedge clk_i);
    end
    if (k == 30) begin
      $display("Error frame_start_o expected 1 seen 0");
      n_mismatch++;
      report_and_stop;
    end
  endtask

  task automatic line_pulse;
    @(posedge clk_i);
    #2 line_end_i = 1'b1;
    @(posedge clk_i);
    #2 line_end_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #2;
  endtask

  initial begin
    nrst_i = 1'b0;
    gain_major_change_i = 1'b0;
    line_end_i = 1'b0;
    coarse_auto_i = 9'h1a5;
    fine_auto_i = 9'h03c;
    repeat (3) @(posedge clk_i);
    #2 nrst_i = 1'b1;
    @(posedge clk_i);
    #2;
    chk("reference", 10'h040, black_reference_o);
    chk("count", 10'h008, 10'(black_pixel_count_o));
    chk("shift", 10'h007, 10'(filter_weight_shift_o));
    chk("outlier", 10'h000, 10'(outlier_filter_en_o));
    chk("coarse", 10'h1a5, {1'b0, coarse_dac_neg_o, coarse_dac_code_o});
    wr(4'h4, 10'h3c3);
    chk("coarse", 10'h1a5, {1'b0, coarse_dac_neg_o, coarse_dac_code_o});
    wr(4'h0, 10'h3ff);
    chk("coarse", 10'h1c3, {1'b0, coarse_dac_neg_o, coarse_dac_code_o});
    chk("manual", 10'h003, {8'h00, coarse_manual_mode_o, fine_manual_mode_o});
    wr(4'h5, 10'h17e);
    chk("fine", 10'h17e, {1'b0, fine_dac_neg_o, fine_dac_code_o});
    wr(4'h0, 10'h040);
    chk("fine", 10'h03c, {1'b0, fine_dac_neg_o, fine_dac_code_o});
    chk("manual", 10'h002, {8'h00, coarse_manual_mode_o, fine_manual_mode_o});
    wr(4'h4, 10'h05a);
    chk("coarse", 10'h05a, {1'b0, coarse_dac_neg_o, coarse_dac_code_o});
    wr(4'h6, 10'h3ff);
    chk("reference", 10'h3ff, black_reference_o);
    // a short frame and an unmapped address must both leave it alone
    host_u.send({2'h0, 4'h6, 10'h155}, 12, 5);
    repeat (8) @(posedge clk_i);
    #2;
    chk("reference", 10'h3ff, black_reference_o);
    wr(4'h9, 10'h000);
    chk("reference", 10'h3ff, black_reference_o);
    for (i = 0; i < 7; i++) begin
      wr(4'h7, sv[i]);
      chk("select", 10'(sv[i][9:8]), 10'(out_select_o));
      chk("hysteresis", 10'(sv[i][7]), 10'(fine_dac_hysteresis_off_o));
      chk("sof weight", 10'(sv[i][5:4]), 10'(frame_start_weight_o));
      chk("count", cnt[i], 10'(black_pixel_count_o));
    end
    wr(4'h8, 10'h000);
    chk("outlier", 10'h001, 10'(outlier_filter_en_o));
    wr(4'h8, 10'h3ff);
    chk("outlier", 10'h000, 10'(outlier_filter_en_o));
    for (i = 0; i < 16; i++) begin
      d = {1'b0, i[0], 1'b0, i[1], i[2], i[3], i[3:0]};
      wr(4'ha, d);
      chk("shift", (i > 8) ? 10'h008 : 10'(i), 10'(filter_weight_shift_o));
      chk("test", i[0] ? 10'h0ff : 10'h000, 10'(black_offset_add_o));
      chk("ground", 10'(i[1]), 10'(video_input_ground_o));
      chk("mode", 10'(i[2]), 10'(input_mode_select_o));
      chk("clamp", 10'(i[3]), 10'(video_clamp_select_o));
    end
    wr(4'h7, 10'h030);
    host_u.send({2'h0, 4'ha, 10'h207}, 16, 3);
    wait_sof;
    repeat (2) @(posedge clk_i);
    #2;
    chk("sof mode", 10'h001, 10'(frame_start_mode_o));
    chk("sof weight", 10'h001, 10'(frame_start_weight_o));
    wr(4'ha, 10'h087);
    line_pulse;
    chk("sof mode", 10'h000, 10'(frame_start_mode_o));
    chk("sof weight", 10'h003, 10'(frame_start_weight_o));
    @(posedge clk_i);
    #2 gain_major_change_i = 1'b1;
    wait_sof;
    #1 gain_major_change_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #2;
    chk("skip", 10'h001, 10'(filter_skip_o));
    chk("sof mode", 10'h001, 10'(frame_start_mode_o));
    line_pulse;
    chk("skip", 10'h000, 10'(filter_skip_o));
    report_and_stop;
  end

  initial begin
    #3000000;
    $display("Error watchdog expected done seen timeout");
    n_mismatch++;
    report_and_stop;
  end
endmodule // tb_black_level_calibration_config
`default_nettype wire
